// ===== rtl/at8_timer.sv
// 8-bit timer with one compare channel behind a classic wishbone slave
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
// Operation
// - counter and compare value are 8-bit registers
// - clock select zero stops the counter
// - tick from io clock or crystal pin
// - cpu counter write beats count or clear
// - counter readable and writable while stopped
// - bottom at 0x00, max at 0xFF
// - top is 0xFF or compare value
// - each tick clears, increments or decrements
// - two waveform mode bits pick the sequence
// - match sets compare flag on next tick
// - enabled flag requests irq; ack or w1c clears
// - pwm modes buffer compare value, others direct
// - buffer copied only at top (0xFF), in both pwm modes
// - buffered mode: cpu reaches the buffer
// - force strobe acts on output in non-pwm modes only, no flag
// - counter write blocks next tick match
// - output state kept across mode change
// - compare output field acts immediately
// - mode 0 wraps, overflow when reaching zero
// - mode 2 clears counter on match
// - mode 3 is single-slope fast pwm
// - field zero leaves output untouched
module at8_timer
  import at8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic crystal_osc_pins_i,
  input wire logic cmp_irq_ack_i,
  input wire logic ovf_irq_ack_i,
  output logic cmp_irq_o,
  output logic ovf_irq_o,
  output logic compare_output_o,
  output logic compare_override_o,
  output logic bottom_o,
  output logic max_o
);
  at8_state_t s_r;
  at8_state_t s_nxt;
  logic req;
  logic wr;
  logic lane0;
  logic base_tick;
  logic tick;
  logic match;
  logic is_pwm;
  logic [7:0] wb;
  logic [1:0] com_nxt;

  assign req = cyc_i & stb_i;
  assign lane0 = sel_i[0];
  assign wr = req & s_r.ack & we_i & lane0;
  assign wb = dat_i[7:0];
  assign is_pwm = s_r.wgm == AT8_WGM_PHASE || s_r.wgm == AT8_WGM_FAST;
  assign match = s_r.cnt == s_r.ocr;
  // io clock every cycle, or a synchronised crystal rising edge
  assign base_tick = s_r.async_sel ? (s_r.xs2 & ~s_r.xprev) : 1'b1;
  assign tick = base_tick && s_r.cs != AT8_CS_OFF &&
                (s_r.psc & AT8_PSC_MASK[s_r.cs]) == AT8_PSC_MASK[s_r.cs];

  always_comb begin
    s_nxt = s_r;
    com_nxt = s_r.com;
    // clears first, so a hardware set later in this process wins
    if (cmp_irq_ack_i || (wr && adr_i == AT8_OFF_FLAG && wb[AT8_CMP_BIT])) begin
      s_nxt.ocf = 1'b0;
    end
    if (ovf_irq_ack_i || (wr && adr_i == AT8_OFF_FLAG && wb[AT8_OVF_BIT])) begin
      s_nxt.tov = 1'b0;
    end
    // crystal synchroniser
    s_nxt.xs1 = crystal_osc_pins_i;
    s_nxt.xs2 = s_r.xs1;
    s_nxt.xprev = s_r.xs2;
    if (base_tick) begin
      s_nxt.psc = s_r.psc + 10'h001;
    end
    // counter sequence
    if (tick) begin
      s_nxt.block = 1'b0;
      unique case (s_r.wgm)
        AT8_WGM_NORMAL: begin
          s_nxt.cnt = s_r.cnt + 8'h01;
          if (s_r.cnt == AT8_MAX) begin
            s_nxt.tov = 1'b1;
          end
        end
        AT8_WGM_CTC: begin
          if (match) begin
            s_nxt.cnt = AT8_BOTTOM;
          end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
          if (s_r.cnt == AT8_MAX) begin
            s_nxt.tov = 1'b1;
          end
        end
        AT8_WGM_FAST: begin
          s_nxt.cnt = s_r.cnt + 8'h01;
          if (s_r.cnt == AT8_MAX) begin
            s_nxt.tov = 1'b1;
            s_nxt.ocr = s_r.ocr_buf;
            if (s_r.com == AT8_COM_CLEAR) begin
              s_nxt.oc = 1'b1;
            end else if (s_r.com == AT8_COM_SET) begin
              s_nxt.oc = 1'b0;
            end
          end
        end
        AT8_WGM_PHASE: begin
          if (!s_r.down) begin
            if (s_r.cnt == AT8_MAX) begin
              s_nxt.down = 1'b1;
              s_nxt.cnt = s_r.cnt - 8'h01;
              s_nxt.ocr = s_r.ocr_buf;
            end else begin
              s_nxt.cnt = s_r.cnt + 8'h01;
            end
          end else begin
            if (s_r.cnt == AT8_BOTTOM) begin
              s_nxt.down = 1'b0;
              s_nxt.cnt = s_r.cnt + 8'h01;
              s_nxt.tov = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt - 8'h01;
            end
          end
        end
      endcase
      // compare match on this tick
      if (match && !s_r.block) begin
        s_nxt.ocf = 1'b1;
        unique case (s_r.wgm)
          AT8_WGM_NORMAL, AT8_WGM_CTC: begin
            if (s_r.com == AT8_COM_TOGGLE) begin
              s_nxt.oc = ~s_r.oc;
            end else if (s_r.com == AT8_COM_CLEAR) begin
              s_nxt.oc = 1'b0;
            end else if (s_r.com == AT8_COM_SET) begin
              s_nxt.oc = 1'b1;
            end
          end
          AT8_WGM_FAST: begin
            if (s_r.com == AT8_COM_CLEAR) begin
              s_nxt.oc = 1'b0;
            end else if (s_r.com == AT8_COM_SET) begin
              s_nxt.oc = 1'b1;
            end
          end
          AT8_WGM_PHASE: begin
            if (s_r.com == AT8_COM_CLEAR) begin
              s_nxt.oc = s_r.down;
            end else if (s_r.com == AT8_COM_SET) begin
              s_nxt.oc = ~s_r.down;
            end
          end
        endcase
      end
    end
    // bus slave: ack one cycle after request, write at acked edge
    s_nxt.ack = req & ~s_r.ack;
    s_nxt.dat = 8'h00;
    if (req && !s_r.ack && !we_i) begin
      unique case (adr_i)
        AT8_OFF_CTRL: s_nxt.dat = {1'b0, s_r.com, s_r.wgm, s_r.cs};
        AT8_OFF_CNT: s_nxt.dat = s_r.cnt;
        AT8_OFF_CMP: s_nxt.dat = is_pwm ? s_r.ocr_buf : s_r.ocr;
        AT8_OFF_FLAG: s_nxt.dat = {6'h00, s_r.tov, s_r.ocf};
        AT8_OFF_MASK: s_nxt.dat = {6'h00, s_r.ie_ovf, s_r.ie_cmp};
        AT8_OFF_ASYNC: s_nxt.dat = {7'h00, s_r.async_sel};
        default: s_nxt.dat = 8'h00;
      endcase
    end
    if (wr) begin
      unique case (adr_i)
        AT8_OFF_CTRL: begin
          com_nxt = wb[AT8_COM_LSB +: 2];
          s_nxt.cs = wb[AT8_CS_LSB +: 3];
          s_nxt.wgm = at8_wgm_t'(wb[AT8_WGM_LSB +: 2]);
          s_nxt.com = com_nxt;
          // forced compare uses the new field, no flag, no clear
          if (wb[AT8_FOC_BIT] && !is_pwm) begin
            if (com_nxt == AT8_COM_TOGGLE) begin
              s_nxt.oc = ~s_r.oc;
            end else if (com_nxt == AT8_COM_CLEAR) begin
              s_nxt.oc = 1'b0;
            end else if (com_nxt == AT8_COM_SET) begin
              s_nxt.oc = 1'b1;
            end
          end
        end
        AT8_OFF_CNT: begin
          s_nxt.cnt = wb;
          s_nxt.block = 1'b1;
        end
        AT8_OFF_CMP: begin
          s_nxt.ocr_buf = wb;
          if (!is_pwm) begin
            s_nxt.ocr = wb;
          end
        end
        AT8_OFF_FLAG: begin
        end
        AT8_OFF_MASK: begin
          s_nxt.ie_cmp = wb[AT8_CMP_BIT];
          s_nxt.ie_ovf = wb[AT8_OVF_BIT];
        end
        AT8_OFF_ASYNC: s_nxt.async_sel = wb[AT8_AS_BIT];
        default: begin
        end
      endcase
    end
    // set on the same cycle as ack keeps the flag
    if (tick && match && !s_r.block) begin
      s_nxt.ocf = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ack_o = s_r.ack;
  assign dat_o = {24'h000000, s_r.dat};
  assign cmp_irq_o = s_r.ocf & s_r.ie_cmp;
  assign ovf_irq_o = s_r.tov & s_r.ie_ovf;
  assign compare_output_o = s_r.oc;
  assign compare_override_o = s_r.com != AT8_COM_NONE;
  assign bottom_o = s_r.cnt == AT8_BOTTOM;
  assign max_o = s_r.cnt == AT8_MAX;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence cnt_write_s;
    wr && adr_i == AT8_OFF_CNT;
  endsequence

  sequence quiet_tick_s;
    tick && match && s_r.block;
  endsequence

  sequence ctrl_write_s;
    wr && adr_i == AT8_OFF_CTRL;
  endsequence

  sequence wrap_tick_s;
    tick && max_o && !wr;
  endsequence

  a_cnt_write_wins: assert property (cnt_write_s |=>
    s_r.cnt == $past(dat_i[7:0]))
    else $error("counter write lost");

  a_stopped_holds: assert property (s_r.cs == AT8_CS_OFF && !wr |=>
    $stable(s_r.cnt))
    else $error("counter moved while stopped");

  a_match_flag: assert property (tick && match && !s_r.block |=>
    s_r.ocf)
    else $error("match did not set flag");

  a_block_match: assert property (cnt_write_s ##1 quiet_tick_s |=>
    !$rose(s_r.ocf))
    else $error("blocked match set flag");

  a_ctc_clear: assert property (tick && match && s_r.wgm == AT8_WGM_CTC && !wr |=>
    s_r.cnt == 8'h00)
    else $error("ctc did not clear");

  a_normal_wrap: assert property (wrap_tick_s ##0 s_r.wgm == AT8_WGM_NORMAL |=>
    bottom_o && s_r.tov)
    else $error("normal wrap wrong");

  a_pwm_buffered: assert property (wr && adr_i == AT8_OFF_CMP && is_pwm && !tick |=>
    $stable(s_r.ocr))
    else $error("pwm compare not buffered");

  a_direct_cmp: assert property (wr && adr_i == AT8_OFF_CMP && !is_pwm |=>
    s_r.ocr == $past(dat_i[7:0]))
    else $error("direct compare write lost");

  a_irq_gate: assert property (cmp_irq_ack_i && !(tick && match && !s_r.block) |=>
    !s_r.ocf)
    else $error("serviced flag not cleared");

  a_ack_pulse: assert property (ack_o |=>
    !ack_o)
    else $error("ack longer than one cycle");

  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=>
    ack_o)
    else $error("request not acknowledged");

  a_no_tick_hold: assert property (!tick && !wr |=>
    s_r.cnt == $past(s_r.cnt))
    else $error("counter moved without tick");

  a_force_no_flag: assert property (ctrl_write_s ##0 (wb[AT8_FOC_BIT] && !s_r.ocf &&
    !(tick && match && !s_r.block)) |=> !s_r.ocf)
    else $error("forced compare set flag");

  a_force_toggle: assert property (ctrl_write_s ##0 (wb[AT8_FOC_BIT] && !is_pwm && !tick &&
    wb[AT8_COM_LSB +: 2] == AT8_COM_TOGGLE) |=> compare_output_o != $past(compare_output_o))
    else $error("forced toggle missing");

  a_com_hold: assert property (s_r.com == AT8_COM_NONE && !wr |=>
    $stable(compare_output_o))
    else $error("output moved with field zero");

  a_mode_keeps_oc: assert property (ctrl_write_s ##0 (!wb[AT8_FOC_BIT] && !tick) |=>
    $stable(compare_output_o))
    else $error("mode change moved output");

  a_com_now: assert property (ctrl_write_s |=>
    s_r.com == $past(wb[AT8_COM_LSB +: 2]))
    else $error("output field not immediate");

  a_phase_down: assert property (tick && s_r.wgm == AT8_WGM_PHASE && s_r.down && !bottom_o && !wr |=>
    s_r.cnt == $past(s_r.cnt) - 8'h01)
    else $error("phase mode did not count down");

  a_fast_wrap: assert property (wrap_tick_s ##0 s_r.wgm == AT8_WGM_FAST |=>
    bottom_o && s_r.tov)
    else $error("fast pwm wrap wrong");

  a_fast_reload: assert property (wrap_tick_s ##0 s_r.wgm == AT8_WGM_FAST |=>
    s_r.ocr == $past(s_r.ocr_buf))
    else $error("buffer not reloaded at top");

  a_ctc_count: assert property (tick && s_r.wgm == AT8_WGM_CTC && !match && !wr |=>
    s_r.cnt == $past(s_r.cnt) + 8'h01)
    else $error("ctc did not count up");

  a_tick_stopped: assert property (s_r.cs == AT8_CS_OFF |->
    !tick)
    else $error("tick while stopped");

  a_set_wins: assert property (tick && match && !s_r.block && cmp_irq_ack_i |=>
    s_r.ocf)
    else $error("service clear beat match");

  a_ovf_ack: assert property (ovf_irq_ack_i && !tick |=>
    !s_r.tov)
    else $error("overflow flag not cleared");

  a_sync_path: assert property (s_r.async_sel && !(s_r.xs2 && !s_r.xprev) |->
    !tick)
    else $error("tick without crystal edge");

  a_io_tick: assert property (!s_r.async_sel && s_r.cs == 3'h1 |->
    tick)
    else $error("io clock tick missing");

endmodule : at8_timer

// ===== rtl/at8_pkg.sv
// package: register map, field layout and state record of the 8-bit timer
package at8_pkg;
  localparam logic [7:0] AT8_OFF_CTRL = 8'h00;
  localparam logic [7:0] AT8_OFF_CNT = 8'h04;
  localparam logic [7:0] AT8_OFF_CMP = 8'h08;
  localparam logic [7:0] AT8_OFF_FLAG = 8'h0C;
  localparam logic [7:0] AT8_OFF_MASK = 8'h10;
  localparam logic [7:0] AT8_OFF_ASYNC = 8'h14;
  // control register fields
  localparam int AT8_CS_LSB = 0;
  localparam int AT8_WGM_LSB = 3;
  localparam int AT8_COM_LSB = 5;
  localparam int AT8_FOC_BIT = 7;
  // flag, mask and async register fields
  localparam int AT8_CMP_BIT = 0;
  localparam int AT8_OVF_BIT = 1;
  localparam int AT8_AS_BIT = 0;
  localparam logic [7:0] AT8_BOTTOM = 8'h00;
  localparam logic [7:0] AT8_MAX = 8'hFF;
  localparam logic [7:0] AT8_RST_BYTE = 8'h00;
  localparam logic [2:0] AT8_CS_OFF = 3'h0;
  localparam logic [1:0] AT8_COM_NONE = 2'h0;
  localparam logic [1:0] AT8_COM_TOGGLE = 2'h1;
  localparam logic [1:0] AT8_COM_CLEAR = 2'h2;
  localparam logic [1:0] AT8_COM_SET = 2'h3;
  // prescaler tap masks, index is the clock select code
  localparam logic [9:0] AT8_PSC_MASK [8] = '{10'h000, 10'h000, 10'h007, 10'h01F,
                                             10'h03F, 10'h07F, 10'h0FF, 10'h3FF};

  typedef enum logic [1:0] {
    AT8_WGM_NORMAL = 2'b00,
    AT8_WGM_PHASE = 2'b01,
    AT8_WGM_CTC = 2'b10,
    AT8_WGM_FAST = 2'b11
  } at8_wgm_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic [7:0] ocr_buf;
    logic [2:0] cs;
    at8_wgm_t wgm;
    logic [1:0] com;
    logic ocf;
    logic tov;
    logic ie_cmp;
    logic ie_ovf;
    logic async_sel;
    logic down;
    logic block;
    logic oc;
    logic [9:0] psc;
    logic xs1;
    logic xs2;
    logic xprev;
    logic ack;
    logic [7:0] dat;
  } at8_state_t;
endpackage : at8_pkg

// ===== verif/tb_at8_timer.sv
// self-checking bench for the 8-bit compare timer
`timescale 1ns/100ps
module tb_at8_timer;
  import at8_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic crystal_osc_pins_i = 1'b0;
  logic cmp_irq_ack_i = 1'b0;
  logic ovf_irq_ack_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, cmp_irq_o, ovf_irq_o, compare_output_o, compare_override_o, bottom_o, max_o;
  logic [3:0] sig;
  logic [32:0] exp_q[$];
  logic [31:0] rd_last = 32'h0;
  logic [7:0] v;
  int n_errors = 0;
  int n_checks = 0;
  int n_cyc = 0;
  assign sig = {ovf_irq_o, cmp_irq_o, bottom_o, max_o};
  at8_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .crystal_osc_pins_i(crystal_osc_pins_i), .cmp_irq_ack_i(cmp_irq_ack_i),
    .ovf_irq_ack_i(ovf_irq_ack_i), .cmp_irq_o(cmp_irq_o), .ovf_irq_o(ovf_irq_o),
    .compare_output_o(compare_output_o), .compare_override_o(compare_override_o),
    .bottom_o(bottom_o), .max_o(max_o));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, g, e);
    end
  endtask : chk32
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: level %b expected %b", $time, g, e);
    end
  endtask : chk1
  // watcher: oldest note against each answer
  always @(posedge clk_i) begin
    if (ack_o === 1'b1) begin
      rd_last = dat_o;
      if (exp_q.size() == 0) chk1(1'b0, 1'b1);
      else if (exp_q[0][32]) chk32(dat_o, exp_q[0][31:0]);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic c,
                    input logic [7:0] e);
    int k;
    exp_q.push_back({c, 24'h0, e});
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (ack_o !== 1'b1) chk1(ack_o, 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(negedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b0, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00, 1'b1, e);
  endtask : rd
  task automatic rq(input logic [7:0] a);
    wb(1'b0, a, 8'h00, 1'b0, 8'h00);
  endtask : rq
  task automatic wait_hi(input int s);
    int k;
    k = 0;
    while (sig[s] !== 1'b1 && k < 1000) begin
      @(posedge clk_i);
      k++;
    end
    chk1(sig[s], 1'b1);
  endtask : wait_hi
  function automatic logic [7:0] cb(input logic [1:0] c, input logic [1:0] m, input logic [2:0] s);
    return {1'b0, c, m, s};
  endfunction : cb
  initial begin
    void'($urandom(32'h136F));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk1(bottom_o, 1'b1);
    chk1(max_o, 1'b0);
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 8'h00);
    v = 8'($urandom_range(1, 254));
    wr(AT8_OFF_CNT, v);
    repeat (20) @(posedge clk_i);
    rd(AT8_OFF_CNT, v);
    wr(AT8_OFF_CMP, ~v);
    rd(AT8_OFF_CMP, ~v);
    wr(AT8_OFF_CNT, 8'hFF);
    chk1(max_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(AT8_OFF_CTRL, {1'b1, 2'(i), 5'h00});
      chk1(compare_output_o, i[0]);
      chk1(compare_override_o, i != 0);
      rd(AT8_OFF_FLAG, 8'h00);
    end
    rd(AT8_OFF_CNT, 8'hFF);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_FAST, 3'h0));
    chk1(compare_output_o, 1'b1);
    wr(AT8_OFF_CMP, 8'h40);
    rd(AT8_OFF_CMP, 8'h40);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_NORMAL, 3'h0));
    wr(AT8_OFF_CMP, 8'h30);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_NORMAL, 3'h1));
    wr(AT8_OFF_CNT, 8'h30);
    wr(AT8_OFF_CTRL, 8'h00);
    rq(AT8_OFF_FLAG);
    chk1(rd_last[0], 1'b0);
    wr(AT8_OFF_FLAG, 8'h03);
    wr(AT8_OFF_MASK, 8'h03);
    wr(AT8_OFF_CNT, 8'h20);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_NORMAL, 3'h1));
    wait_hi(2);
    @(posedge clk_i);
    cmp_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    cmp_irq_ack_i <= 1'b0;
    @(negedge clk_i);
    chk1(cmp_irq_o, 1'b0);
    wait_hi(3);
    @(posedge clk_i);
    ovf_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    ovf_irq_ack_i <= 1'b0;
    @(negedge clk_i);
    chk1(ovf_irq_o, 1'b0);
    wait_hi(2);
    wr(AT8_OFF_CTRL, 8'h00);
    wr(AT8_OFF_FLAG, 8'h01);
    rq(AT8_OFF_FLAG);
    chk1(rd_last[0], 1'b0);
    wr(AT8_OFF_CNT, 8'h00);
    wr(AT8_OFF_CMP, 8'h05);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_CTC, 3'h1));
    repeat (40) @(posedge clk_i);
    wr(AT8_OFF_CTRL, 8'h00);
    rq(AT8_OFF_CNT);
    chk1(rd_last[7:0] <= 8'h05, 1'b1);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_FAST, 3'h1));
    wait_hi(0);
    wait_hi(1);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_PHASE, 3'h1));
    wait_hi(0);
    wr(AT8_OFF_CTRL, 8'h00);
    rq(AT8_OFF_CNT);
    chk1(rd_last[7:0] > 8'h80, 1'b1);
    wr(AT8_OFF_CNT, 8'h00);
    wr(AT8_OFF_ASYNC, 8'h01);
    wr(AT8_OFF_CTRL, cb(AT8_COM_NONE, AT8_WGM_NORMAL, 3'h1));
    repeat (10) @(posedge clk_i);
    rd(AT8_OFF_CNT, 8'h00);
    repeat (5) begin
      @(posedge clk_i);
      crystal_osc_pins_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      crystal_osc_pins_i <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
    wr(AT8_OFF_CTRL, 8'h00);
    rd(AT8_OFF_CNT, 8'h05);
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule : tb_at8_timer
